// ---- rtl/fsew_params.svh ----
`ifndef FSEW_PARAMS_SVH
`define FSEW_PARAMS_SVH
// Command codes
`define FSEW_CMD_READ_ARRAY 8'hff
`define FSEW_CMD_READ_STATUS 8'h70
`define FSEW_CMD_CLEAR_STATUS 8'h50
`define FSEW_CMD_ERASE_SETUP 8'h20
`define FSEW_CMD_CONFIRM 8'hd0
`define FSEW_CMD_WRITE_SETUP 8'h40
`define FSEW_CMD_WRITE_SETUP_ALT 8'h10
`define FSEW_CMD_SUSPEND 8'hb0
// Status bit positions
`define FSEW_SR_READY 7
`define FSEW_SR_ERASE_SUSP 6
`define FSEW_SR_ERASE_ERR 5
`define FSEW_SR_WRITE_ERR 4
`define FSEW_SR_SUPPLY_ERR 3
`define FSEW_SR_WRITE_SUSP 2
`define FSEW_SR_PROTECT_ERR 1
// Bus strobe timing at 20 MHz
`define FSEW_CLOCK_NS 50
`define FSEW_STROBE_NS 100
`define FSEW_STROBE_CYC (((`FSEW_STROBE_NS)+(`FSEW_CLOCK_NS)-1)/(`FSEW_CLOCK_NS))
`define FSEW_ACCESS_NS 150
`define FSEW_ACCESS_CYC (((`FSEW_ACCESS_NS)+(`FSEW_CLOCK_NS)-1)/(`FSEW_CLOCK_NS))
`define FSEW_RESET_VAL 8'h00
`endif

// ---- rtl/fsew_pkg.sv ----
package fsew_pkg;
	typedef enum logic [2:0] {
		FSEW_OP_READ_STATUS = 3'h0,
		FSEW_OP_CLEAR_STATUS = 3'h1,
		FSEW_OP_ERASE = 3'h2,
		FSEW_OP_WRITE = 3'h3,
		FSEW_OP_SUSPEND = 3'h4,
		FSEW_OP_RESUME = 3'h5,
		FSEW_OP_READ_ARRAY = 3'h6,
		FSEW_OP_READ = 3'h7
	} fsew_op_t;
	typedef struct packed {
		fsew_op_t op;
		logic [20:0] addr;
		logic [7:0] data;
	} fsew_req_t;
	typedef struct packed {
		logic chip_sel_n;
		logic write_n;
		logic out_en_n;
		logic [20:0] addr;
		logic [7:0] dq_out;
		logic dq_oe;
	} fsew_pins_t;
endpackage

// ---- rtl/fsew_bus_cycle.sv ----
`timescale 1ns/1ps
`include "fsew_params.svh"
module fsew_bus_cycle (
	input wire logic clock,
	input wire logic reset,
	input wire logic start,
	input wire logic is_write,
	input wire logic [20:0] addr,
	input wire logic [7:0] data,
	input wire logic [7:0] dq_in,
	output fsew_pkg::fsew_pins_t pins,
	output logic busy,
	output logic done,
	output logic [7:0] rdata
);
	import fsew_pkg::*;
	typedef enum logic [1:0] {
		FSEW_BC_IDLE = 2'h0,
		FSEW_BC_ACT = 2'h1,
		FSEW_BC_REC = 2'h2
	} fsew_bc_state_t;
	typedef struct packed {
		fsew_bc_state_t st;
		logic [2:0] cnt;
		logic wr;
		fsew_pins_t pins;
		logic done;
		logic [7:0] rdata;
	} fsew_bc_t;
	fsew_bc_t r;
	fsew_bc_t next_r;
	always_comb begin
		next_r = r;
		next_r.done = 1'b0;
		unique case (r.st)
			FSEW_BC_IDLE: begin
				if (start) begin
					next_r.st = FSEW_BC_ACT;
					next_r.wr = is_write;
					next_r.pins.addr = addr;
					next_r.pins.dq_out = data;
					next_r.pins.dq_oe = is_write;
					next_r.pins.chip_sel_n = 1'b0;
					next_r.pins.write_n = ~is_write;
					next_r.pins.out_en_n = is_write;
					next_r.cnt = is_write ? 3'(`FSEW_STROBE_CYC)
						: 3'(`FSEW_ACCESS_CYC);
				end
			end
			FSEW_BC_ACT: begin
				if (r.cnt > 3'h1) begin
					next_r.cnt = r.cnt - 3'h1;
				end else begin
					// Sample before strobes rise; write data latches on the rise
					next_r.rdata = dq_in;
					next_r.pins.chip_sel_n = 1'b1;
					next_r.pins.write_n = 1'b1;
					next_r.pins.out_en_n = 1'b1;
					next_r.st = FSEW_BC_REC;
				end
			end
			FSEW_BC_REC: begin
				// One idle cycle so every read sees a fresh strobe fall
				next_r.pins.dq_oe = 1'b0;
				next_r.done = 1'b1;
				next_r.st = FSEW_BC_IDLE;
			end
			default: next_r.st = FSEW_BC_IDLE;
		endcase
	end
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			r <= '{st: FSEW_BC_IDLE, cnt: 3'h0, wr: 1'b0,
				pins: '{1'b1, 1'b1, 1'b1, 21'h0, 8'h00, 1'b0},
				done: 1'b0, rdata: 8'h00};
		end else begin
			r <= next_r;
		end
	end
	assign pins = r.pins;
	assign busy = (r.st != FSEW_BC_IDLE);
	assign done = r.done;
	assign rdata = r.rdata;
	strobe_release_a: assert property (@(posedge clock) disable iff (reset)
		(r.st == FSEW_BC_REC) |-> (r.pins.chip_sel_n && r.pins.out_en_n))
		else $error("strobes not raised after cycle");
	done_spacing_a: assert property (@(posedge clock) disable iff (reset)
		$rose(r.pins.chip_sel_n) |=> done)
		else $error("done not one cycle after strobe rise");
endmodule

// ---- rtl/fsew_host.sv ----
`timescale 1ns/1ps
`include "fsew_params.svh"
module fsew_host (
	input wire logic clock,
	input wire logic reset,
	input wire logic req_valid,
	input fsew_pkg::fsew_req_t req,
	output logic req_ready,
	output logic resp_valid,
	output logic [7:0] resp_data,
	output logic [7:0] status,
	output logic erase_suspended,
	output logic write_suspended,
	output logic chip_sel_n,
	output logic write_n,
	output logic out_en_n,
	output logic [20:0] addr,
	output logic [7:0] dq_out,
	output logic dq_oe,
	output logic powerdown_reset_n,
	input wire logic [7:0] dq_in,
	input wire logic ready_busy_n
);
	import fsew_pkg::*;
	typedef enum logic [2:0] {
		FSEW_IDLE = 3'h0,
		FSEW_CMD1 = 3'h1,
		FSEW_CMD2 = 3'h2,
		FSEW_RD = 3'h3,
		FSEW_WAIT = 3'h4,
		FSEW_POLL = 3'h5,
		FSEW_DONE = 3'h6
	} fsew_state_t;
	typedef struct packed {
		fsew_state_t st;
		fsew_req_t cur;
		logic rdy_s1;
		logic rdy_s2;
		logic ready;
		logic rvalid;
		logic [7:0] rdata;
		logic [7:0] status;
		logic esusp;
		logic wsusp;
		logic status_mode;
		logic pd_n;
	} fsew_host_t;
	fsew_host_t r;
	fsew_host_t next_r;
	logic bc_start;
	logic bc_wr;
	logic [20:0] bc_addr;
	logic [7:0] bc_data;
	logic bc_busy;
	logic bc_done;
	logic [7:0] bc_rdata;
	logic [7:0] dq_s1;
	logic [7:0] dq_s2;
	fsew_pins_t bc_pins;
	// Data pins come from the device's domain; two stages before use
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			dq_s1 <= 8'h00;
			dq_s2 <= 8'h00;
		end else begin
			dq_s1 <= dq_in;
			dq_s2 <= dq_s1;
		end
	end
	function automatic logic [7:0] first_code(input fsew_req_t q);
		unique case (q.op)
			FSEW_OP_READ_STATUS: first_code = `FSEW_CMD_READ_STATUS;
			FSEW_OP_CLEAR_STATUS: first_code = `FSEW_CMD_CLEAR_STATUS;
			FSEW_OP_ERASE: first_code = `FSEW_CMD_ERASE_SETUP;
			FSEW_OP_WRITE: first_code = `FSEW_CMD_WRITE_SETUP;
			FSEW_OP_SUSPEND: first_code = `FSEW_CMD_SUSPEND;
			FSEW_OP_RESUME: first_code = `FSEW_CMD_CONFIRM;
			FSEW_OP_READ_ARRAY: first_code = `FSEW_CMD_READ_ARRAY;
			FSEW_OP_READ: first_code = `FSEW_CMD_READ_ARRAY;
		endcase
	endfunction
	function automatic logic allowed(input fsew_req_t q, input logic es,
		input logic ws);
		// Requests the device would ignore are answered, not sent
		if (ws) begin
			allowed = q.op inside {FSEW_OP_READ_STATUS, FSEW_OP_RESUME,
				FSEW_OP_READ_ARRAY, FSEW_OP_READ};
		end else if (es) begin
			allowed = q.op != FSEW_OP_CLEAR_STATUS
				&& q.op != FSEW_OP_ERASE;
		end else begin
			allowed = q.op != FSEW_OP_RESUME && q.op != FSEW_OP_SUSPEND;
		end
	endfunction
	always_comb begin
		next_r = r;
		next_r.rvalid = 1'b0;
		next_r.rdy_s1 = ready_busy_n;
		next_r.rdy_s2 = r.rdy_s1;
		next_r.pd_n = 1'b1;
		bc_start = 1'b0;
		bc_wr = 1'b1;
		bc_addr = r.cur.addr;
		bc_data = first_code(r.cur);
		unique case (r.st)
			FSEW_IDLE: begin
				next_r.ready = 1'b1;
				if (req_valid && r.ready) begin
					next_r.cur = req;
					next_r.ready = 1'b0;
					if (!allowed(req, r.esusp, r.wsusp)) begin
						next_r.rdata = r.status;
						next_r.st = FSEW_DONE;
					end else if (req.op == FSEW_OP_READ && r.status_mode) begin
						next_r.st = FSEW_RD;
					end else if (req.op == FSEW_OP_READ) begin
						next_r.st = FSEW_RD;
					end else begin
						next_r.st = FSEW_CMD1;
					end
				end
			end
			FSEW_CMD1: begin
				// Done shows with busy low; a start then would repeat the cycle
				bc_start = !bc_busy && !bc_done;
				if (bc_done) begin
					unique case (r.cur.op)
						FSEW_OP_ERASE, FSEW_OP_WRITE: next_r.st = FSEW_CMD2;
						FSEW_OP_CLEAR_STATUS: begin
							next_r.status[5:1] = 5'h00;
							next_r.st = FSEW_DONE;
						end
						FSEW_OP_READ_ARRAY: begin
							next_r.status_mode = 1'b0;
							next_r.st = FSEW_DONE;
						end
						FSEW_OP_RESUME: begin
							next_r.status_mode = 1'b1;
							next_r.status[`FSEW_SR_READY] = 1'b0;
							if (r.wsusp) begin
								next_r.wsusp = 1'b0;
							end else begin
								next_r.esusp = 1'b0;
							end
							next_r.st = FSEW_WAIT;
						end
						default: begin
							next_r.status_mode = 1'b1;
							next_r.st = (r.cur.op == FSEW_OP_SUSPEND)
								? FSEW_POLL : FSEW_RD;
						end
					endcase
				end
			end
			FSEW_CMD2: begin
				bc_start = !bc_busy && !bc_done;
				bc_data = (r.cur.op == FSEW_OP_ERASE)
					? `FSEW_CMD_CONFIRM : r.cur.data;
				if (bc_done) begin
					next_r.status_mode = 1'b1;
					next_r.status[`FSEW_SR_READY] = 1'b0;
					next_r.st = FSEW_WAIT;
				end
			end
			FSEW_WAIT: begin
				// Give ready/busy time to fall through the synchroniser
				next_r.st = FSEW_POLL;
			end
			FSEW_POLL: begin
				bc_start = !bc_busy && !bc_done;
				bc_wr = 1'b0;
				if (bc_done && r.rdy_s2 && bc_rdata[`FSEW_SR_READY]) begin
					next_r.status = bc_rdata;
					next_r.esusp = bc_rdata[`FSEW_SR_ERASE_SUSP];
					next_r.wsusp = bc_rdata[`FSEW_SR_WRITE_SUSP];
					next_r.rdata = bc_rdata;
					next_r.st = FSEW_DONE;
				end
			end
			FSEW_RD: begin
				bc_start = !bc_busy && !bc_done;
				bc_wr = 1'b0;
				if (bc_done) begin
					next_r.rdata = bc_rdata;
					if (r.status_mode && bc_rdata[`FSEW_SR_READY]) begin
						next_r.status = bc_rdata;
					end
					next_r.st = FSEW_DONE;
				end
			end
			FSEW_DONE: begin
				next_r.rvalid = 1'b1;
				next_r.ready = 1'b1;
				next_r.st = FSEW_IDLE;
			end
			default: next_r.st = FSEW_IDLE;
		endcase
	end
	fsew_bus_cycle bus (
		.clock(clock),
		.reset(reset),
		.start(bc_start),
		.is_write(bc_wr),
		.addr(bc_addr),
		.data(bc_data),
		.dq_in(dq_s2),
		.pins(bc_pins),
		.busy(bc_busy),
		.done(bc_done),
		.rdata(bc_rdata)
	);
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			r <= '{st: FSEW_IDLE, cur: '{FSEW_OP_READ_STATUS, 21'h0, 8'h00},
				rdy_s1: 1'b1, rdy_s2: 1'b1, ready: 1'b0, rvalid: 1'b0,
				rdata: `FSEW_RESET_VAL, status: 8'h80, esusp: 1'b0,
				wsusp: 1'b0, status_mode: 1'b0, pd_n: 1'b0};
		end else begin
			r <= next_r;
		end
	end
	assign req_ready = r.ready;
	assign resp_valid = r.rvalid;
	assign resp_data = r.rdata;
	assign status = r.status;
	assign erase_suspended = r.esusp;
	assign write_suspended = r.wsusp;
	assign powerdown_reset_n = r.pd_n;
	assign chip_sel_n = bc_pins.chip_sel_n;
	assign write_n = bc_pins.write_n;
	assign out_en_n = bc_pins.out_en_n;
	assign addr = bc_pins.addr;
	assign dq_out = bc_pins.dq_out;
	assign dq_oe = bc_pins.dq_oe;
	clear_blocked_a: assert property (@(posedge clock) disable iff (reset)
		(r.st == FSEW_IDLE && r.ready && req_valid
		&& req.op == FSEW_OP_CLEAR_STATUS && (r.esusp || r.wsusp))
		|=> (r.st == FSEW_DONE))
		else $error("clear sent during suspend");
	clear_status_a: assert property (@(posedge clock) disable iff (reset)
		(r.st == FSEW_CMD1 && bc_done && r.cur.op == FSEW_OP_CLEAR_STATUS)
		|=> (r.status[5:1] == 5'h00))
		else $error("error bits not cleared");
	erase_confirm_a: assert property (@(posedge clock) disable iff (reset)
		(r.st == FSEW_CMD2 && bc_start && r.cur.op == FSEW_OP_ERASE)
		|=> (dq_out == 8'hd0 && !write_n))
		else $error("erase confirm code wrong");
	status_mode_a: assert property (@(posedge clock) disable iff (reset)
		(r.st == FSEW_CMD2 && bc_done) |=> r.status_mode)
		else $error("no status mode after sequence");
	poll_ready_a: assert property (@(posedge clock) disable iff (reset)
		(r.st == FSEW_POLL && bc_done && !(r.rdy_s2 && bc_rdata[7]))
		|=> (r.st == FSEW_POLL && $stable(r.status)))
		else $error("status taken while busy");
	setup_code_a: assert property (@(posedge clock) disable iff (reset)
		(r.st == FSEW_CMD1 && bc_start && r.cur.op == FSEW_OP_WRITE)
		|=> (dq_out == 8'h40))
		else $error("write setup code wrong");
	suspend_code_a: assert property (@(posedge clock) disable iff (reset)
		(r.st == FSEW_CMD1 && bc_start && r.cur.op == FSEW_OP_SUSPEND)
		|=> (dq_out == 8'hb0))
		else $error("suspend code wrong");
	read_status_a: assert property (@(posedge clock) disable iff (reset)
		(r.st == FSEW_CMD1 && bc_start && r.cur.op == FSEW_OP_READ_STATUS)
		|=> (dq_out == 8'h70))
		else $error("read status code wrong");
	wsusp_gate_a: assert property (@(posedge clock) disable iff (reset)
		(r.wsusp && r.st == FSEW_CMD1) |-> (r.cur.op != FSEW_OP_ERASE))
		else $error("erase sent under write suspend");
endmodule

// ---- verif/fsew_flash_model.sv ----
`timescale 1ns/1ps
module fsew_flash_model #(
	parameter int ERASE_NS = 2000,
	parameter int WRITE_NS = 800
) (
	input wire logic chip_sel_n,
	input wire logic write_n,
	input wire logic out_en_n,
	input wire logic [20:0] addr,
	input wire logic [7:0] dq_out,
	input wire logic powerdown_reset_n,
	input wire logic program_supply_lockout,
	input wire logic [31:0] locked,
	output logic [7:0] dq_in,
	output logic ready_busy_n
);
	logic [7:0] mem [logic [20:0]];
	logic [7:0] sr;
	logic [7:0] latch;
	logic [7:0] setup;
	logic mode;
	logic act_q;
	wire we_act = !write_n && !chip_sel_n;
	wire rd_act = !out_en_n && !chip_sel_n;
	initial begin
		dq_in = 8'h00;
		act_q = 1'b0;
		sr = 8'h80;
		mode = 1'b0;
		setup = 8'h00;
		latch = 8'h00;
		ready_busy_n = 1'b1;
	end
	function automatic logic [7:0] rdm(input logic [20:0] a);
		return mem.exists(a) ? mem[a] : 8'hff;
	endfunction
	// Power-down doubles as reset; array mode afterwards
	always @(negedge powerdown_reset_n) begin
		sr = 8'h80;
		mode = 1'b0;
		setup = 8'h00;
	end
	task automatic start(input logic er, input logic [20:0] a,
		input logic [7:0] d);
		logic [20:0] ks[$];
		ready_busy_n = 1'b0;
		sr[7] = 1'b0;
		fork
			begin
				#(er ? ERASE_NS : WRITE_NS);
				if (er) begin
					foreach (mem[k]) if (k[20:16] == a[20:16]) ks.push_back(k);
					foreach (ks[i]) mem.delete(ks[i]);
				end else begin
					// Only ones can fall; zero-to-one goes unflagged
					mem[a] = rdm(a) & d;
				end
				sr[7] = 1'b1;
				ready_busy_n = 1'b1;
			end
		join_none
	endtask
	// Capture on whichever strobe rises first
	always @(negedge we_act) begin
		if (powerdown_reset_n === 1'b1 && ready_busy_n) begin
			if (setup == 8'h20) begin
				mode = 1'b1;
				if (dq_out != 8'hd0) sr[5:4] = 2'b11;
				else if (program_supply_lockout) sr = sr | 8'h28;
				else if (locked[addr[20:16]]) sr = sr | 8'h22;
				else start(1'b1, addr, dq_out);
				setup = 8'h00;
			end else if (setup == 8'h40 || setup == 8'h10) begin
				mode = 1'b1;
				if (program_supply_lockout) sr = sr | 8'h18;
				else if (locked[addr[20:16]]) sr = sr | 8'h12;
				else start(1'b0, addr, dq_out);
				setup = 8'h00;
			end else begin
				setup = dq_out;
				// Clear is dead while either suspend flag stands
				if (dq_out == 8'h50 && !sr[6] && !sr[2])
					sr = sr & 8'hc5;
				else if (dq_out == 8'hff) mode = 1'b0;
				else if (dq_out != 8'hb0) mode = 1'b1;
			end
		end
	end
	// Released bus shows the inverse; each addr change while released inverts it again
	always @(rd_act or addr) begin
		if (rd_act && !act_q) latch = sr;
		act_q = rd_act;
		if (rd_act) dq_in = mode ? latch : rdm(addr);
		else dq_in = ~dq_in;
	end
endmodule

// ---- verif/fsew_host_tb_top.sv ----
`timescale 1ns/1ps
module fsew_host_tb_top;
	import fsew_pkg::*;
	logic clock, reset, req_valid, req_ready, resp_valid;
	logic erase_suspended, write_suspended, chip_sel_n, write_n, out_en_n;
	logic dq_oe, powerdown_reset_n, ready_busy_n, supply_low;
	fsew_req_t req;
	logic [7:0] resp_data, status, dq_out, dq_in;
	logic [20:0] addr;
	logic [31:0] locked;
	int bad_count, n_compared;
	localparam logic [20:0] A = 21'h000010;
	fsew_host fsew_host_i (.clock(clock), .reset(reset),
		.req_valid(req_valid), .req(req), .req_ready(req_ready),
		.resp_valid(resp_valid), .resp_data(resp_data), .status(status),
		.erase_suspended(erase_suspended), .write_suspended(write_suspended),
		.chip_sel_n(chip_sel_n), .write_n(write_n), .out_en_n(out_en_n),
		.addr(addr), .dq_out(dq_out), .dq_oe(dq_oe),
		.powerdown_reset_n(powerdown_reset_n), .dq_in(dq_in),
		.ready_busy_n(ready_busy_n));
	fsew_flash_model fsew_flash_model_i (.chip_sel_n(chip_sel_n),
		.write_n(write_n), .out_en_n(out_en_n), .addr(addr),
		.dq_out(dq_out), .powerdown_reset_n(powerdown_reset_n),
		.program_supply_lockout(supply_low), .locked(locked),
		.dq_in(dq_in), .ready_busy_n(ready_busy_n));
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	task automatic end_sim;
		if (bad_count == 0 && n_compared > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// Reads and read-status requests are judged on data, other requests on the status copy
	task automatic run(input fsew_op_t op, input logic [20:0] a,
		input logic [7:0] d, input logic [7:0] e);
		int n;
		logic [7:0] got;
		req_valid <= 1'b1;
		req <= '{op: op, addr: a, data: d};
		n = 0;
		do begin
			@(negedge clock);
			n++;
		end while (req_ready !== 1'b1 && n < 100);
		if (req_ready !== 1'b1) begin
			bad_count++;
			end_sim;
		end
		@(posedge clock);
		req_valid <= 1'b0;
		n = 0;
		do begin
			@(negedge clock);
			n++;
		end while (resp_valid !== 1'b1 && n < 4000);
		if (resp_valid !== 1'b1) begin
			bad_count++;
			end_sim;
		end
		got = (op == FSEW_OP_READ || op == FSEW_OP_READ_STATUS) ?
			resp_data : status;
		n_compared++;
		if (got !== e) begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, e);
		end
		@(posedge clock);
	endtask
	initial begin
		reset = 1'b1;
		req_valid = 1'b0;
		req = '0;
		supply_low = 1'b0;
		locked = 32'h0000_0002;
		bad_count = 0;
		n_compared = 0;
		repeat (4) @(posedge clock);
		reset <= 1'b0;
		repeat (2) @(posedge clock);
		run(FSEW_OP_READ_STATUS, A, 8'h00, 8'h80);
		run(FSEW_OP_READ, A, 8'h00, 8'h80);
		run(FSEW_OP_WRITE, A, 8'h3c, 8'h80);
		run(FSEW_OP_READ, A, 8'h00, 8'h80);
		run(FSEW_OP_READ_ARRAY, A, 8'h00, 8'h80);
		run(FSEW_OP_READ, A, 8'h00, 8'h3c);
		run(FSEW_OP_WRITE, A, 8'h0f, 8'h80);
		run(FSEW_OP_READ_ARRAY, A, 8'h00, 8'h80);
		run(FSEW_OP_READ, A, 8'h00, 8'h0c);
		run(FSEW_OP_ERASE, 21'h000020, 8'h00, 8'h80);
		run(FSEW_OP_READ, A, 8'h00, 8'h80);
		run(FSEW_OP_READ_ARRAY, A, 8'h00, 8'h80);
		run(FSEW_OP_READ, A, 8'h00, 8'hff);
		supply_low <= 1'b1;
		run(FSEW_OP_ERASE, A, 8'h00, 8'ha8);
		run(FSEW_OP_WRITE, A, 8'h00, 8'hb8);
		run(FSEW_OP_CLEAR_STATUS, A, 8'h00, 8'h80);
		run(FSEW_OP_READ_STATUS, A, 8'h00, 8'h80);
		supply_low <= 1'b0;
		run(FSEW_OP_READ_ARRAY, A, 8'h00, 8'h80);
		run(FSEW_OP_READ, A, 8'h00, 8'hff);
		run(FSEW_OP_ERASE, 21'h010000, 8'h00, 8'ha2);
		run(FSEW_OP_CLEAR_STATUS, A, 8'h00, 8'h80);
		run(FSEW_OP_WRITE, 21'h010004, 8'h55, 8'h92);
		run(FSEW_OP_CLEAR_STATUS, A, 8'h00, 8'h80);
		run(FSEW_OP_READ_STATUS, A, 8'h00, 8'h80);
		run(FSEW_OP_SUSPEND, A, 8'h00, 8'h80);
		run(FSEW_OP_RESUME, A, 8'h00, 8'h80);
		run(FSEW_OP_READ, A, 8'h00, 8'h80);
		end_sim;
	end
endmodule
